/* File: hw/adc_out_defs.svh */
// constants for the converter output side
`ifndef ADC_OUT_DEFS_SVH
`define ADC_OUT_DEFS_SVH
`define CODE_BITS 12
`define WORD_BITS 13
`define CODE_MSB 11
`define OVR_BIT 12
`define FIFO_WORDS 8
`define CODE_RESET 12'h000
`define WORD_RESET 13'h0000
`endif

/* File: hw/adc_out_pkg.sv */
// types for the converter output side
`include "adc_out_defs.svh"
package adc_out_pkg;
  typedef logic [`CODE_BITS-1:0] code_t;
  typedef logic [`WORD_BITS-1:0] word_t;
  typedef struct packed {
    logic strobe_s1;
    logic strobe_s2;
    logic strobe_d;
    logic fmt_s1;
    logic fmt_s2;
    logic oen_s1;
    logic oen_s2;
    code_t code_s1;
    code_t code_s2;
    logic above_s1;
    logic above_s2;
    logic below_s1;
    logic below_s2;
    logic pend_valid;
    word_t pend_word;
    logic upd_pending;
    code_t data_reg;
    logic ovr_reg;
    logic strobe_reg;
    logic oe_reg;
  } state_t;
endpackage

/* File: hw/word_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic push;
  logic pop;

  assign in_ready = (st_reg.count != FULL_COUNT);
  assign out_valid = (st_reg.count != '0);
  assign out_data = st_reg.mem[st_reg.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr = (st_reg.wr_ptr == LAST_PTR) ? '0 : st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = (st_reg.rd_ptr == LAST_PTR) ? '0 : st_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

/* File: hw/adc_encode_and_parallel_output.sv */
// output side of the sampling converter: capture, buffer, format, drive
`timescale 1ns/1ps
`include "adc_out_defs.svh"
module adc_encode_and_parallel_output (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sample_strobe,
  input wire logic format_select,
  input wire logic output_enable_n,
  input wire logic [`CODE_BITS-1:0] core_code,
  input wire logic core_above,
  input wire logic core_below,
  output logic [`CODE_BITS-1:0] data_out,
  output logic data_oe,
  output logic overrange_flag,
  output logic overrange_oe,
  output logic data_ready_strobe,
  output logic data_ready_oe,
  output logic sample_lost
);
  adc_out_pkg::state_t st_reg;
  adc_out_pkg::state_t st_next;
  logic lost_reg;
  logic lost_next;

  adc_out_pkg::word_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic strobe_rise;
  logic strobe_fall;
  adc_out_pkg::word_t sampled_word;

  word_fifo #(
    .WIDTH(`WORD_BITS),
    .DEPTH(`FIFO_WORDS)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_data(st_reg.pend_word),
    .in_valid(st_reg.pend_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  // edges are found on the second sync stage only
  assign strobe_rise = st_reg.strobe_s2 && !st_reg.strobe_d;
  assign strobe_fall = !st_reg.strobe_s2 && st_reg.strobe_d;
  // the core code is steady through the hold phase, so the synced bus is coherent at the rise
  assign sampled_word = {st_reg.above_s2 || st_reg.below_s2, st_reg.code_s2};
  // draining stops while outputs float, so the fifo fills during idle
  assign fifo_out_ready = st_reg.upd_pending && st_reg.oen_s2;

  always_comb begin
    st_next = st_reg;
    lost_next = 1'b0;
    st_next.strobe_s1 = sample_strobe;
    st_next.strobe_s2 = st_reg.strobe_s1;
    st_next.strobe_d = st_reg.strobe_s2;
    st_next.fmt_s1 = format_select;
    st_next.fmt_s2 = st_reg.fmt_s1;
    st_next.oen_s1 = output_enable_n;
    st_next.oen_s2 = st_reg.oen_s1;
    st_next.code_s1 = core_code;
    st_next.code_s2 = st_reg.code_s1;
    st_next.above_s1 = core_above;
    st_next.above_s2 = st_reg.above_s1;
    st_next.below_s1 = core_below;
    st_next.below_s2 = st_reg.below_s1;

    if (st_reg.pend_valid && fifo_in_ready) begin
      st_next.pend_valid = 1'b0;
    end
    // sample is held at the encode rise; a full buffer drops the older pending word
    if (strobe_rise) begin
      lost_next = st_reg.pend_valid && !fifo_in_ready;
      st_next.pend_valid = 1'b1;
      st_next.pend_word = sampled_word;
    end

    st_next.strobe_reg = st_reg.strobe_s2;
    st_next.upd_pending = strobe_fall;
    if (fifo_out_ready && fifo_out_valid) begin
      st_next.ovr_reg = fifo_out[`OVR_BIT];
      if (st_reg.fmt_s2) begin
        st_next.data_reg = fifo_out[`CODE_MSB:0];
      end else begin
        st_next.data_reg = {~fifo_out[`CODE_MSB], fifo_out[`CODE_MSB-1:0]};
      end
    end
    st_next.oe_reg = st_reg.oen_s2;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
      lost_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      lost_reg <= lost_next;
    end
  end

  assign data_out = st_reg.data_reg;
  assign overrange_flag = st_reg.ovr_reg;
  assign data_ready_strobe = st_reg.strobe_reg;
  assign data_oe = st_reg.oe_reg;
  assign overrange_oe = st_reg.oe_reg;
  assign data_ready_oe = st_reg.oe_reg;
  assign sample_lost = lost_reg;
endmodule

/* File: verif/adc_out_monitor.sv */
// port assertions for the converter output side
`timescale 1ns/1ps
module adc_out_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sample_strobe,
  input wire logic output_enable_n,
  input wire logic [11:0] data_out,
  input wire logic data_oe,
  input wire logic overrange_flag,
  input wire logic overrange_oe,
  input wire logic data_ready_strobe,
  input wire logic data_ready_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // pin is async, so expect the edge three cycles later, after two sync stages and the output register
  AST_STROBE_COPY: assert property ($changed(data_ready_strobe) && data_ready_oe
    && $past(data_ready_oe) |-> $past(sample_strobe, 3) == data_ready_strobe
    && $past(sample_strobe, 6) != data_ready_strobe)
    else $error("strobe does not follow the encode pin");
  AST_WORD_AFTER_FALL: assert property ($changed(data_out) && data_oe && $past(data_oe)
    |-> !data_ready_strobe && !$past(data_ready_strobe) && $past(data_ready_strobe, 2))
    else $error("word changed away from a strobe fall");
  // the flag travels with the word, so it may only move where the word may
  AST_FLAG_AFTER_FALL: assert property ($changed(overrange_flag) && data_oe
    && $past(data_oe) |-> !data_ready_strobe && $past(data_ready_strobe, 2))
    else $error("flag changed away from a strobe fall");
  AST_STEADY_WHILE_HIGH: assert property (data_ready_strobe && $past(data_ready_strobe)
    |-> $stable(data_out) && $stable(overrange_flag))
    else $error("word or flag moved while the strobe was high");
  AST_FLOAT_ON_DISABLE: assert property (output_enable_n == 1'b0 [*4] |=> !data_oe && !overrange_oe && !data_ready_oe)
    else $error("outputs still driven while disabled");
  AST_DRIVE_ON_ENABLE: assert property (output_enable_n [*4] |=> data_oe && overrange_oe && data_ready_oe)
    else $error("outputs not driven while enabled");
endmodule

/* File: verif/word_latch.sv */
// receiving latch: takes flag and word together on the strobe rise
`timescale 1ns/1ps
module word_latch (
  input wire logic data_ready_strobe,
  input wire logic [11:0] data_out,
  input wire logic data_oe,
  input wire logic overrange_flag,
  output adc_out_pkg::word_t held
);
  initial held = 13'h0000;
  // floating bus reads as the inverse of the last word, never a lucky match
  always @(posedge data_ready_strobe) held <= data_oe ? {overrange_flag, data_out} : ~held;
endmodule

/* File: verif/tb_adc_encode_and_parallel_output.sv */
// random samples through the converter output side
`timescale 1ns/1ps
module tb_adc_encode_and_parallel_output;
  logic clk = 0, reset_n = 0, sample_strobe = 0, format_select = 1, output_enable_n = 1;
  logic core_above = 0, core_below = 0;
  logic data_oe, overrange_flag, overrange_oe, data_ready_strobe, data_ready_oe, sample_lost;
  adc_out_pkg::code_t core_code = 12'h000, data_out;
  adc_out_pkg::word_t held, exp_w;
  int failures = 0, n_checks = 0, n_lost = 0, seed = 32'hd285;
  adc_encode_and_parallel_output adc_encode_and_parallel_output_i (.clk, .reset_n,
    .sample_strobe, .format_select, .output_enable_n, .core_code, .core_above, .core_below,
    .data_out, .data_oe, .overrange_flag, .overrange_oe, .data_ready_strobe, .data_ready_oe,
    .sample_lost);
  word_latch word_latch_i (.data_ready_strobe, .data_out, .data_oe, .overrange_flag, .held);
  always #20 clk = ~clk;
  // odd offset keeps the encode edges off the clk edges; the encode period is a fixed 8 clk periods
  initial begin
    #13;
    forever #160 sample_strobe = ~sample_strobe;
  end
  always @(posedge clk) if (sample_lost === 1'b1) n_lost++;
  function automatic adc_out_pkg::word_t expect_w(logic f, adc_out_pkg::code_t c, logic a, b);
    return {a | b, f ? c : c ^ 12'h800};
  endfunction
  task check(adc_out_pkg::word_t got, adc_out_pkg::word_t exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d mismatches=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    test_done();
  end
  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1;
    for (int i = 0; i < 40; i++) begin
      @(negedge sample_strobe);
      @(negedge clk);
      format_select = (i < 4) ? i[0] : 1'($random(seed));
      core_code = (i < 4) ? {i[1], 11'h7ff} : 12'($random(seed));
      core_above = (i % 5 == 1);
      core_below = (i % 7 == 2);
      exp_w = expect_w(format_select, core_code, core_above, core_below);
      repeat (2) @(posedge data_ready_strobe);
      #1 check(held, exp_w);
    end
    $display("sample stream test done");
    // idle with outputs off long enough to overflow fifo and pending slot
    @(negedge clk);
    output_enable_n = 0;
    repeat (100) @(negedge clk);
    check({10'h000, data_oe, overrange_oe, data_ready_oe}, 13'h0000);
    check(13'(n_lost != 0), 13'h0001);
    output_enable_n = 1;
    repeat (130) @(negedge clk);
    check(held, exp_w);
    $display("output enable test done");
    test_done();
  end
endmodule
bind adc_encode_and_parallel_output adc_out_monitor adc_out_monitor_i (.clk, .reset_n,
  .sample_strobe, .output_enable_n, .data_out, .data_oe, .overrange_flag, .overrange_oe,
  .data_ready_strobe, .data_ready_oe);
